/* bench/gpeh_asserts.sv */
// Checker of pin ownership, reset state and bus answer timing for the port block.
module gpeh_asserts #(
  parameter int ADDR_W = 12
) (
  input wire logic                 pclk,                // Clock.
  input wire logic                 presetn,             // Reset, low.
  input wire logic                 clk_en,              // Clock enable.
  input wire logic                 psel,                // Select.
  input wire logic                 penable,             // Access phase.
  input wire logic                 pwrite,              // Direction.
  input wire logic [ADDR_W-1:0]    paddr,               // Address.
  input wire gpeh_pkg::gpeh_word_t pwdata,              // Write data.
  input wire logic [3:0]           pstrb,               // Strobes.
  input wire logic                 pready,              // Ready.
  input wire logic                 pslverr,             // Error.
  input wire logic [7:0]           pin_e_oe,            // E enables.
  input wire logic [7:0]           pin_e_out,           // E values.
  input wire logic [6:0]           pin_f_oe,            // F enables.
  input wire logic [2:0]           pin_g_oe,            // G enables.
  input wire logic [1:0]           pin_h_oe,            // H enables.
  input wire logic [7:0]           serial_e_own,        // Serial owns E.
  input wire logic [7:0]           serial_e_oe,         // Serial enables.
  input wire logic [7:0]           serial_e_out,        // Serial values.
  input wire logic [6:0]           timer_f_own,         // Timer owns F.
  input wire logic [6:0]           timer_f_oe,          // Timer enables.
  input wire logic [4:0]           keyboard_irq_enable  // Keyboard enables.
);
  import gpeh_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Write data of the last edge, so the new drive can be tied to it.
  logic [2:0] g_wd;
  always_ff @(posedge pclk) begin
    g_wd <= pwdata[2:0];
  end
  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  sequence s_wr_gdir;
    psel && penable && pready && pwrite && pstrb[0] && !pslverr && paddr[7:0] == 8'h38;
  endsequence
  property p_rdy; s_setup ##1 (psel && penable && clk_en) |-> pready; endproperty
  property p_g_dir; s_wr_gdir |=> pin_g_oe == (g_wd & ~keyboard_irq_enable[2:0]); endproperty
  property p_rst; $rose(presetn) |-> !(pin_g_oe | pin_h_oe) && !(pin_e_oe & ~serial_e_own);
  endproperty
  property p_e_oe; (serial_e_own & (pin_e_oe ^ serial_e_oe)) == 8'h00; endproperty
  property p_e_out; (serial_e_own & (pin_e_out ^ serial_e_out)) == 8'h00; endproperty
  property p_f_oe; (timer_f_own[5:0] & (pin_f_oe[5:0] ^ timer_f_oe[5:0])) == 6'h00; endproperty
  property p_g_kbd; (keyboard_irq_enable[2:0] & pin_g_oe) == 3'h0; endproperty
  property p_h_kbd; (keyboard_irq_enable[4:3] & pin_h_oe) == 2'h0; endproperty
  a_rdy: assert property (p_rdy) else $error("access without zero-wait answer");
  a_g_dir: assert property (p_g_dir) else $error("drive differs from direction");
  a_rst: assert property (p_rst) else $error("pin driven after reset");
  a_e_oe: assert property (p_e_oe) else $error("serial enable not used");
  a_e_out: assert property (p_e_out) else $error("serial value not used");
  a_f_oe: assert property (p_f_oe) else $error("timer enable not used");
  a_g_kbd: assert property (p_g_kbd) else $error("keyboard G pin driven");
  a_h_kbd: assert property (p_h_kbd) else $error("keyboard H pin driven");
endmodule
bind gpeh_top gpeh_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

/* bench/gpeh_pins.sv */
// Outside circuitry: resolves each pin from the port drive and an outside level.
module gpeh_pins #(
  parameter int W = 20
) (
  input  wire logic [W-1:0] oe,   // Port drive enable.
  input  wire logic [W-1:0] drv,  // Port drive value.
  input  wire logic [W-1:0] ext,  // Level the outside pulls to.
  output logic      [W-1:0] lvl   // Level on the pin.
);
  timeunit 1ns;
  timeprecision 1ns;
  // A floating pin shows the outside level, never a stale drive.
  always_comb lvl = (oe & drv) | (~oe & ext);
endmodule

/* bench/test_gpio_ports_e_to_h.sv */
// Self-checking bench for the port E to H register block.
`include "gpeh_defines.svh"
module test_gpio_ports_e_to_h;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr;
  wire  [19:0] oe_all, out_all, in_all;
  logic [19:0] ext_all = 20'h5a5a5;
  logic [7:0]  ser_own = 8'h00, ser_oe = 8'h00, ser_out = 8'h00;
  logic [6:0]  tmr_own = 7'h00, tmr_oe = 7'h00, tmr_out = 7'h00;
  logic [4:0]  keyboard_wake_pin = 5'h00;
  int          miscompares = 0, n_checks = 0;
  localparam int WID[4] = '{`GPEH_E_W, `GPEH_F_W, `GPEH_G_W, `GPEH_H_W};
  localparam int LO[4] = '{0, 8, 15, 18};
  always #5 pclk = ~pclk;
  gpeh_top DUT (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_e_in(in_all[7:0]), .pin_e_out(out_all[7:0]),
    .pin_e_oe(oe_all[7:0]), .pin_f_in(in_all[14:8]), .pin_f_out(out_all[14:8]),
    .pin_f_oe(oe_all[14:8]), .pin_g_in(in_all[17:15]), .pin_g_out(out_all[17:15]),
    .pin_g_oe(oe_all[17:15]), .pin_h_in(in_all[19:18]), .pin_h_out(out_all[19:18]),
    .pin_h_oe(oe_all[19:18]), .serial_e_own(ser_own), .serial_e_oe(ser_oe),
    .serial_e_out(ser_out), .timer_f_own(tmr_own), .timer_f_oe(tmr_oe),
    .timer_f_out(tmr_out), .keyboard_irq_enable(keyboard_wake_pin));
  gpeh_pins #(.W(20)) u_far (.oe(oe_all), .drv(out_all), .ext(ext_all), .lvl(in_all));
  // ==========================================================================
  // Comparison, bus transfer and closing tasks.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // Starts after an edge and ends on the edge where pready is sampled high.
  task automatic xfer(input logic wr, input int idx, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= 12'(4 * idx);
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    // A transfer that never got its answer counts as a mismatch.
    if (pready !== 1'b1) miscompares++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input int idx, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, idx, d, q, e);
  endtask
  task automatic rd_chk(input int idx, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    xfer(1'b0, idx, 32'h0, q, e);
    chk({q[31:1], q[0] | e}, exp);
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog: the tests need a few hundred cycles at most.
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
  // ==========================================================================
  // Tests: latch versus pin per port, reset retention, pin ownership, bad address.
  initial begin
    logic [31:0] m, d, p, a, pe;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      m = (32'h1 << WID[i]) - 1;
      d = 32'h53 & m;
      p = 32'h6a & m;
      a = (ext_all >> LO[i]) & m;
      rd_chk(`GPEH_IDX_E_DIR + i, 32'h0);
      wr(`GPEH_IDX_E_DATA + i, d);
      rd_chk(`GPEH_IDX_E_DATA + i, a);
      wr(`GPEH_IDX_E_DIR + i, p);
      rd_chk(`GPEH_IDX_E_DATA + i, (d & p) | (a & ~p));
      chk((oe_all >> LO[i]) & m, p);
      chk((out_all >> LO[i]) & m, d);
    end
    $display("test latch_vs_pin done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      m = (32'h1 << WID[i]) - 1;
      rd_chk(`GPEH_IDX_E_DIR + i, 32'h0);
      wr(`GPEH_IDX_E_DIR + i, m);
      rd_chk(`GPEH_IDX_E_DATA + i, 32'h53 & m);
    end
    $display("test reset_retention done");
    ser_own <= 8'hf0;
    ser_oe <= 8'ha5;
    ser_out <= 8'h3c;
    tmr_own <= 7'h7f;
    tmr_oe <= 7'h15;
    tmr_out <= 7'h2a;
    keyboard_wake_pin <= 5'h1f;
    wr(`GPEH_IDX_E_DIR, 32'h0f);
    pe = (8'ha0 & 8'h3c) | (8'h5f & ext_all[7:0]);
    rd_chk(`GPEH_IDX_E_DATA, (32'h03) | (pe & 32'hf0));
    rd_chk(`GPEH_IDX_F_DATA, 32'h53);
    chk(oe_all, {5'h00, 7'h55, 8'ha0 | 8'h0f});
    chk(out_all, {2'h3, 3'h3, 7'h6a, 8'h30 | 8'h03});
    $display("test ownership done");
    rd_chk(0, 32'h1);
    $display("test unmapped done");
    give_verdict();
  end
endmodule

/* core/gpeh_defines.svh */
// Register indices, field widths and reset values for the port E to H block.
// ==========================================================================
// Functional notes
// [RL1] Direction one drives pin, zero floats it.
// [RL2] Reset clears all direction bits to input.
// [RL3] Port E read gives latch when output.
// [RL4] Input-configured bits read the sampled pin level.
// [RL5] Data writes always update the latch.
// [RL6] Input pin readback unaffected by latch writes.
// [RL7] Port F read gives latch when output.
// [RL8] Port G read gives latch when output.
// [RL9] Port H read gives latch when output.
// [RL10] Reset leaves port F latches unchanged.
// [RL11] Reset leaves port G latches unchanged.
// [RL12] Reset leaves port H latches unchanged.
// [RL13] Port F bits serve as timer channels; only bits 5:0 can be timer-owned here, bit 6 never is.
// [RL14] Timer-owned F pins ignore direction for drive.
// [RL15] Port G keyboard enable forces input.
// [RL16] Port H keyboard enables 4,3 force input.
// [RL17] Software loads latch before enabling output.
// [RL18] Serial-owned E pins ignore direction for drive.
// [RL19] Owning peripheral supplies enable and value.
`ifndef GPEH_DEFINES_SVH
`define GPEH_DEFINES_SVH

// ==========================================================================
// Register indices; byte address is four times the index.
`define GPEH_IDX_E_DATA   4'h8
`define GPEH_IDX_F_DATA   4'h9
`define GPEH_IDX_G_DATA   4'ha
`define GPEH_IDX_H_DATA   4'hb
`define GPEH_IDX_E_DIR    4'hc
`define GPEH_IDX_F_DIR    4'hd
`define GPEH_IDX_G_DIR    4'he
`define GPEH_IDX_H_DIR    4'hf

// ==========================================================================
// Port widths.
`define GPEH_E_W          8
`define GPEH_F_W          7
`define GPEH_G_W          3
`define GPEH_H_W          2

// ==========================================================================
// Reset values of the direction registers.
`define GPEH_E_DIR_RST    8'h00
`define GPEH_F_DIR_RST    7'h00
`define GPEH_G_DIR_RST    3'h0
`define GPEH_H_DIR_RST    2'h0

`endif

/* core/gpeh_pkg.sv */
// Types shared by the port E to H block.
`include "gpeh_defines.svh"

package gpeh_pkg;

  // ========================================================================
  // Register selected by a bus address.
  typedef enum logic [3:0] {
    GPEH_SEL_NONE,
    GPEH_SEL_E_DATA,
    GPEH_SEL_F_DATA,
    GPEH_SEL_G_DATA,
    GPEH_SEL_H_DATA,
    GPEH_SEL_E_DIR,
    GPEH_SEL_F_DIR,
    GPEH_SEL_G_DIR,
    GPEH_SEL_H_DIR
  } gpeh_sel_t;

  typedef logic [31:0] gpeh_word_t;

endpackage

/* core/gpeh_top.sv */
// APB register slave and pin logic for general-purpose ports E, F, G and H.
`include "gpeh_defines.svh"

module gpeh_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic                     pclk,          // Bus clock.
  input  wire logic                     presetn,       // Asynchronous reset, low.
  input  wire logic                     clk_en,        // Freezes all state while low.
  input  wire logic                     psel,          // APB select.
  input  wire logic                     penable,       // APB access phase.
  input  wire logic                     pwrite,        // APB direction.
  input  wire logic [ADDR_W-1:0]        paddr,         // APB byte address.
  input  wire gpeh_pkg::gpeh_word_t     pwdata,        // APB write data.
  input  wire logic [3:0]               pstrb,         // APB byte strobes.
  output gpeh_pkg::gpeh_word_t          prdata,        // APB read data.
  output logic                          pready,        // APB ready.
  output logic                          pslverr,       // APB error, unmapped.
  input  wire logic [`GPEH_E_W-1:0]     pin_e_in,      // Port E pin levels.
  output logic      [`GPEH_E_W-1:0]     pin_e_out,     // Port E drive values.
  output logic      [`GPEH_E_W-1:0]     pin_e_oe,      // Port E drive enables.
  input  wire logic [`GPEH_F_W-1:0]     pin_f_in,      // Port F pin levels.
  output logic      [`GPEH_F_W-1:0]     pin_f_out,     // Port F drive values.
  output logic      [`GPEH_F_W-1:0]     pin_f_oe,      // Port F drive enables.
  input  wire logic [`GPEH_G_W-1:0]     pin_g_in,      // Port G pin levels.
  output logic      [`GPEH_G_W-1:0]     pin_g_out,     // Port G drive values.
  output logic      [`GPEH_G_W-1:0]     pin_g_oe,      // Port G drive enables.
  input  wire logic [`GPEH_H_W-1:0]     pin_h_in,      // Port H pin levels.
  output logic      [`GPEH_H_W-1:0]     pin_h_out,     // Port H drive values.
  output logic      [`GPEH_H_W-1:0]     pin_h_oe,      // Port H drive enables.
  input  wire logic [`GPEH_E_W-1:0]     serial_e_own,  // Serial units own E pins.
  input  wire logic [`GPEH_E_W-1:0]     serial_e_oe,   // Serial drive enables.
  input  wire logic [`GPEH_E_W-1:0]     serial_e_out,  // Serial drive values.
  input  wire logic [`GPEH_F_W-1:0]     timer_f_own,   // Timer channels own F pins.
  input  wire logic [`GPEH_F_W-1:0]     timer_f_oe,    // Timer drive enables.
  input  wire logic [`GPEH_F_W-1:0]     timer_f_out,   // Timer drive values.
  input  wire logic [4:0]               keyboard_irq_enable // Keyboard input enables.
);
  import gpeh_pkg::*;

  // ========================================================================
  // Parameter check.
  // The index decode needs address bits 5:2 at least.
  if (ADDR_W < 6) begin : g_bad_addr
    $error("gpeh_top needs ADDR_W of at least 6");
  end

  // ========================================================================
  // Decode helpers.

  // Maps a byte address to a register; anything off-word or out of map is none.
  function automatic gpeh_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] idx;
    gpeh_sel_t         sel;
    idx = addr >> 2;
    sel = GPEH_SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      if (idx == ADDR_W'(`GPEH_IDX_E_DATA)) sel = GPEH_SEL_E_DATA;
      if (idx == ADDR_W'(`GPEH_IDX_F_DATA)) sel = GPEH_SEL_F_DATA;
      if (idx == ADDR_W'(`GPEH_IDX_G_DATA)) sel = GPEH_SEL_G_DATA;
      if (idx == ADDR_W'(`GPEH_IDX_H_DATA)) sel = GPEH_SEL_H_DATA;
      if (idx == ADDR_W'(`GPEH_IDX_E_DIR))  sel = GPEH_SEL_E_DIR;
      if (idx == ADDR_W'(`GPEH_IDX_F_DIR))  sel = GPEH_SEL_F_DIR;
      if (idx == ADDR_W'(`GPEH_IDX_G_DIR))  sel = GPEH_SEL_G_DIR;
      if (idx == ADDR_W'(`GPEH_IDX_H_DIR))  sel = GPEH_SEL_H_DIR;
    end
    return sel;
  endfunction

  // Per-bit read mux: latch where the direction bit is one, pin otherwise.
  function automatic logic [7:0] port_read(input logic [7:0] dir,
                                           input logic [7:0] latch,
                                           input logic [7:0] pin);
    return (dir & latch) | (~dir & pin);
  endfunction

  // ========================================================================
  // Storage.
  logic [`GPEH_E_W-1:0] port_e_data_latch;
  logic [`GPEH_F_W-1:0] port_f_data_latch;
  logic [`GPEH_G_W-1:0] port_g_data_latch;
  logic [`GPEH_H_W-1:0] port_h_data_latch;
  logic [`GPEH_E_W-1:0] port_e_direction;
  logic [`GPEH_F_W-1:0] port_f_direction;
  logic [`GPEH_G_W-1:0] port_g_direction;
  logic [`GPEH_H_W-1:0] port_h_direction;

  // ========================================================================
  // Bus handshake.
  gpeh_sel_t  bus_sel;
  logic       rd_valid;
  logic       xfer_done;
  logic       wr_go;
  gpeh_word_t next_prdata;

  assign bus_sel = decode(paddr);

  // The answer waits until read data was captured at an enabled edge, so a
  // frozen clock enable during setup only stretches the transfer.
  assign pready    = psel & penable & rd_valid & clk_en;
  assign xfer_done = pready;
  assign pslverr   = pready & (bus_sel == GPEH_SEL_NONE);
  assign wr_go     = xfer_done & pwrite & pstrb[0];

  // Marks that prdata holds a capture for the current request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      if (xfer_done) begin
        rd_valid <= 1'b0;
      end else if (psel) begin
        rd_valid <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Read data selection.
  always_comb begin
    next_prdata = '0;
    unique case (bus_sel)
      GPEH_SEL_E_DATA: next_prdata[7:0] = port_read(port_e_direction,   // see [RL3]
                                                    port_e_data_latch,  // see [RL4]
                                                    pin_e_in);          // see [RL18]
      GPEH_SEL_F_DATA: next_prdata[7:0] = port_read({1'b0, port_f_direction},     // see [RL7]
                                                    {1'b0, port_f_data_latch},    // see [RL14]
                                                    {1'b0, pin_f_in});            // see [RL4]
      GPEH_SEL_G_DATA: next_prdata[7:0] = port_read({5'h00, port_g_direction},    // see [RL8]
                                                    {5'h00, port_g_data_latch},
                                                    {5'h00, pin_g_in});           // see [RL6]
      GPEH_SEL_H_DATA: next_prdata[7:0] = port_read({6'h00, port_h_direction},    // see [RL9]
                                                    {6'h00, port_h_data_latch},
                                                    {6'h00, pin_h_in});
      GPEH_SEL_E_DIR:  next_prdata[7:0] = port_e_direction;
      GPEH_SEL_F_DIR:  next_prdata[7:0] = {1'b0, port_f_direction};
      GPEH_SEL_G_DIR:  next_prdata[7:0] = {5'h00, port_g_direction};
      GPEH_SEL_H_DIR:  next_prdata[7:0] = {6'h00, port_h_direction};
      GPEH_SEL_NONE:   next_prdata      = '0;
    endcase
  end

  // Read data is registered; pins are sampled at the capture edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (clk_en && psel && !pwrite && !xfer_done) begin
      prdata <= next_prdata;
    end
  end

  // ========================================================================
  // Data latches.
  // No reset here: the latches keep their contents across reset, and
  // software is expected to load them before turning pins to outputs.
  always_ff @(posedge pclk) begin
    if (clk_en && wr_go) begin
      if (bus_sel == GPEH_SEL_E_DATA) begin
        port_e_data_latch <= pwdata[`GPEH_E_W-1:0];  // see [RL5]
      end
      if (bus_sel == GPEH_SEL_F_DATA) begin
        port_f_data_latch <= pwdata[`GPEH_F_W-1:0];  // see [RL10]
      end
      if (bus_sel == GPEH_SEL_G_DATA) begin
        port_g_data_latch <= pwdata[`GPEH_G_W-1:0];  // see [RL11]
      end
      if (bus_sel == GPEH_SEL_H_DATA) begin
        port_h_data_latch <= pwdata[`GPEH_H_W-1:0];  // see [RL12]
      end
    end
  end

  // ========================================================================
  // Direction registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_e_direction <= `GPEH_E_DIR_RST;  // see [RL2]
      port_f_direction <= `GPEH_F_DIR_RST;
      port_g_direction <= `GPEH_G_DIR_RST;
      port_h_direction <= `GPEH_H_DIR_RST;
    end else if (clk_en && wr_go) begin
      if (bus_sel == GPEH_SEL_E_DIR) begin
        port_e_direction <= pwdata[`GPEH_E_W-1:0];
      end
      if (bus_sel == GPEH_SEL_F_DIR) begin
        port_f_direction <= pwdata[`GPEH_F_W-1:0];
      end
      if (bus_sel == GPEH_SEL_G_DIR) begin
        port_g_direction <= pwdata[`GPEH_G_W-1:0];
      end
      if (bus_sel == GPEH_SEL_H_DIR) begin
        port_h_direction <= pwdata[`GPEH_H_W-1:0];
      end
    end
  end

  // ========================================================================
  // Pin drive.
  // Drive is combinational from the registers so that a pin follows its
  // owner without a cycle of lag; the data itself comes from flip-flops.

  // Port E: serial units take over drive of the pins they own.
  for (genvar i = 0; i < `GPEH_E_W; i++) begin : g_pin_e
    assign pin_e_oe[i]  = serial_e_own[i] ? serial_e_oe[i]  : port_e_direction[i];  // see [RL1]
    assign pin_e_out[i] = serial_e_own[i] ? serial_e_out[i] : port_e_data_latch[i]; // see [RL19]
  end

  // Port F: bits 3:0 are first-timer channels 5:2, bits 5:4 second-timer
  // channels 1:0; bit 6 is never owned.
  for (genvar i = 0; i < `GPEH_F_W; i++) begin : g_pin_f
    logic owned;
    assign owned        = (i < 6) ? timer_f_own[i] : 1'b0;                  // see [RL13]
    assign pin_f_oe[i]  = owned ? timer_f_oe[i]  : port_f_direction[i];     // see [RL14]
    assign pin_f_out[i] = owned ? timer_f_out[i] : port_f_data_latch[i];    // see [RL19]
  end

  // Ports G and H: an enabled keyboard input forces the pin to input.
  assign pin_g_oe  = port_g_direction & ~keyboard_irq_enable[2:0];  // see [RL15]
  assign pin_g_out = port_g_data_latch;
  assign pin_h_oe  = port_h_direction & ~keyboard_irq_enable[4:3];  // see [RL16]
  assign pin_h_out = port_h_data_latch;

endmodule
